// ==== rtl/rvam_top.v ====
// Relocatable vector address map: sources, pending, arbitration
// ==========================================================
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "rvam_defines.vh"
module rvam_top (
   input  wire        CLK,
   input  wire        RESET_N,
   input  wire        HSEL,
   input  wire [31:0] HADDR,
   input  wire [1:0]  HTRANS,
   input  wire        HWRITE,
   input  wire [2:0]  HSIZE,
   input  wire [31:0] HWDATA,
   input  wire        HREADY,
   output wire [31:0] HRDATA,
   output wire        HREADYOUT,
   output wire        HRESP,
   input  wire [3:0]  DMA_DONE,
   input  wire [4:0]  TMRA_REQ,
   input  wire [5:0]  TMRB_REQ,
   input  wire [4:0]  SER_TX_REQ,
   input  wire [4:0]  SER_RX_REQ,
   input  wire [4:0]  SER_NACK,
   input  wire [4:0]  SER_ACK,
   input  wire [4:0]  SER_BUS_EVT,
   input  wire [5:0]  EXT_REQUEST_PIN,
   input  wire        ADC_CHANNEL_ZERO_DONE,
   input  wire        KEY_REQ,
   input  wire        CORE_GLOBAL_ENABLE,
   input  wire [2:0]  PROCESSOR_PRIORITY_LEVEL,
   output wire [23:0] MEM_ADDR,
   output wire        MEM_RD,
   input  wire [7:0]  MEM_RDATA,
   output wire [31:0] HANDLER_ADDR,
   output wire        HANDLER_VALID,
   output wire [5:0]  HANDLER_VEC,
   output wire        HANDLER_SW
);
   localparam ARB_IDLE = 1'b0;
   localparam ARB_WAIT = 1'b1;
   localparam NSRC     = `RVAM_NUM_SRC;

   // ==========================================================
   // Storage
   reg [23:0] vector_base_register_q;
   reg [4:0]  i2c_mode_q;
   reg        ch0_ch3_event_vector_select_q;
   reg        ch1_ch4_event_vector_select_q;
   reg [2:0]  source_priority_level_q [0:NSRC-1];
   reg [NSRC-1:0] request_pending_bit_q;
   reg [NSRC-1:0] req_prev_q;
   reg [5:0]  ext_s1_q;
   reg [5:0]  ext_s2_q;
   reg        trap_pend_q;
   reg [5:0]  trap_vec_q;
   reg        arb_q;
   reg        start_q;
   reg [5:0]  st_vec_q;
   reg        st_sw_q;
   reg [5:0]  ack_idx_q;

   wire [11:0] reg_addr;
   wire        wr_stb;
   wire        fetch_busy;
   wire        fetch_done;
   reg  [31:0] rdata;
   reg  [NSRC-1:0] req_raw;
   reg  [2:0]  best_lvl;
   reg  [5:0]  best_idx;
   reg         hit;
   integer     i;

   // ==========================================================
   // Decode helpers
   function [5:0] src_to_vec;
      input [5:0] idx;
      begin
         src_to_vec = idx + `RVAM_VEC_HW_LO;
      end
   endfunction

   function src_hit;
      input [11:0] addr;
      begin
         src_hit = (addr[11:8] == `RVAM_SRC_PAGE) && (addr[7:2] < NSRC);
      end
   endfunction

   wire       src_wr  = wr_stb && src_hit(reg_addr);
   wire [5:0] src_sel = reg_addr[7:2];

   // ==========================================================
   // Bus slave
   rvam_ahb u_ahb (
      .clk         (CLK),
      .rst_n       (RESET_N),
      .hsel        (HSEL),
      .haddr       (HADDR[11:0]),
      .htrans      (HTRANS),
      .hwrite      (HWRITE),
      .hready      (HREADY),
      .rdata       (rdata),
      .hrdata_q    (HRDATA),
      .hreadyout_q (HREADYOUT),
      .hresp_q     (HRESP),
      .addr_q      (reg_addr),
      .wr_q        (wr_stb)
   );

   // ==========================================================
   // Handler fetch engine
   rvam_fetch u_fetch (
      .clk        (CLK),
      .rst_n      (RESET_N),
      .start      (start_q),
      .vec        (st_vec_q),
      .sw         (st_sw_q),
      .base       (vector_base_register_q),
      .mem_rdata  (MEM_RDATA),
      .mem_addr_q (MEM_ADDR),
      .mem_rd_q   (MEM_RD),
      .handler_q  (HANDLER_ADDR),
      .vec_q      (HANDLER_VEC),
      .sw_q       (HANDLER_SW),
      .done_q     (HANDLER_VALID),
      .busy_q     (fetch_busy)
   );
   assign fetch_done = HANDLER_VALID;

   // ==========================================================
   // Pin synchroniser for the external request pins
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         ext_s1_q <= 6'h00;
         ext_s2_q <= 6'h00;
      end
      else
      begin
         ext_s1_q <= EXT_REQUEST_PIN;
         ext_s2_q <= ext_s1_q;
      end
   end

   // ==========================================================
   // Source to slot map, index is vector minus eight
   always @*
   begin
      req_raw = {NSRC{1'b0}};
      for (i = 0; i < 4; i = i + 1)
         req_raw[`RVAM_VEC_HW_LO - `RVAM_VEC_HW_LO + i] = DMA_DONE[i];
      for (i = 0; i < 5; i = i + 1)
         req_raw[`RVAM_VEC_TMRA - `RVAM_VEC_HW_LO + i] = TMRA_REQ[i];
      for (i = 0; i < 2; i = i + 1)
      begin
         req_raw[`RVAM_VEC_SER01 - `RVAM_VEC_HW_LO + 2*i] =
            i2c_mode_q[i] ? SER_NACK[i] : SER_TX_REQ[i];
         req_raw[`RVAM_VEC_SER01 - `RVAM_VEC_HW_LO + 2*i + 1] =
            i2c_mode_q[i] ? SER_ACK[i] : SER_RX_REQ[i];
      end
      for (i = 0; i < 5; i = i + 1)
         req_raw[`RVAM_VEC_TMRB - `RVAM_VEC_HW_LO + i] = TMRB_REQ[i];
      for (i = 0; i < 6; i = i + 1)
         req_raw[`RVAM_VEC_EXT - `RVAM_VEC_HW_LO + i] = ext_s2_q[5-i];
      req_raw[`RVAM_VEC_TMRB5 - `RVAM_VEC_HW_LO] = TMRB_REQ[5];
      for (i = 2; i < 5; i = i + 1)
      begin
         req_raw[`RVAM_VEC_SER24 - `RVAM_VEC_HW_LO + 2*(i-2)] =
            i2c_mode_q[i] ? SER_NACK[i] : SER_TX_REQ[i];
         req_raw[`RVAM_VEC_SER24 - `RVAM_VEC_HW_LO + 2*(i-2) + 1] =
            i2c_mode_q[i] ? SER_ACK[i] : SER_RX_REQ[i];
      end
      req_raw[`RVAM_VEC_EVT2 - `RVAM_VEC_HW_LO] = SER_BUS_EVT[2];
      req_raw[`RVAM_VEC_EVT03 - `RVAM_VEC_HW_LO] =
         ch0_ch3_event_vector_select_q ? SER_BUS_EVT[0] : SER_BUS_EVT[3];
      req_raw[`RVAM_VEC_EVT14 - `RVAM_VEC_HW_LO] =
         ch1_ch4_event_vector_select_q ? SER_BUS_EVT[1] : SER_BUS_EVT[4];
      req_raw[`RVAM_VEC_ADC0 - `RVAM_VEC_HW_LO] = ADC_CHANNEL_ZERO_DONE;
      req_raw[`RVAM_VEC_KEY - `RVAM_VEC_HW_LO] = KEY_REQ;
   end

   // ==========================================================
   // Arbitration: highest level above PROCESSOR_PRIORITY_LEVEL, lowest vector on a tie
   always @*
   begin
      best_lvl = 3'h0;
      best_idx = 6'h00;
      hit      = 1'b0;
      for (i = 0; i < NSRC; i = i + 1)
         if (request_pending_bit_q[i] &&
             source_priority_level_q[i] > best_lvl &&
             source_priority_level_q[i] > PROCESSOR_PRIORITY_LEVEL)
         begin
            best_lvl = source_priority_level_q[i];
            best_idx = i[5:0];
            hit      = 1'b1;
         end
   end

   // ==========================================================
   // Register read mux
   always @*
   begin
      rdata = 32'h00000000;
      case (reg_addr)
         `RVAM_OFS_VBASE: rdata = {8'h00, vector_base_register_q};
         `RVAM_OFS_CTRL:  rdata = {25'h0000000, ch1_ch4_event_vector_select_q,
                                   ch0_ch3_event_vector_select_q, i2c_mode_q};
         `RVAM_OFS_TRAP:  rdata = {23'h000000, trap_pend_q, 2'h0, trap_vec_q};
         `RVAM_OFS_STAT:  rdata = {22'h000000, HANDLER_SW, fetch_busy, 2'h0,
                                   HANDLER_VEC};
         `RVAM_OFS_HNDL:  rdata = HANDLER_ADDR;
         default:
            if (src_hit(reg_addr))
               rdata = {28'h0000000, request_pending_bit_q[src_sel],
                        source_priority_level_q[src_sel]};
      endcase
   end

   // ==========================================================
   // Control registers
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         vector_base_register_q        <= `RVAM_VBASE_RST;
         i2c_mode_q                    <= `RVAM_I2C_RST;
         ch0_ch3_event_vector_select_q <= 1'b0;
         ch1_ch4_event_vector_select_q <= 1'b0;
      end
      else if (wr_stb)
      begin
         // Odd bases work; even ones only save fetch time upstream
         if (reg_addr == `RVAM_OFS_VBASE)
            vector_base_register_q <= HWDATA[23:0];
         if (reg_addr == `RVAM_OFS_CTRL)
         begin
            i2c_mode_q                    <= HWDATA[4:0];
            ch0_ch3_event_vector_select_q <= HWDATA[`RVAM_CTRL_SEL03];
            ch1_ch4_event_vector_select_q <= HWDATA[`RVAM_CTRL_SEL14];
         end
      end
   end

   // ==========================================================
   // Per-source level and pending bit; a new edge beats any clear
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         request_pending_bit_q <= {NSRC{1'b0}};
         req_prev_q            <= {NSRC{1'b0}};
         for (i = 0; i < NSRC; i = i + 1)
            source_priority_level_q[i] <= `RVAM_LVL_RST;
      end
      else
      begin
         req_prev_q <= req_raw;
         for (i = 0; i < NSRC; i = i + 1)
            request_pending_bit_q[i] <= (req_raw[i] & ~req_prev_q[i]) |
               (request_pending_bit_q[i] &
                ~(src_wr && src_sel == i[5:0] && !HWDATA[`RVAM_SRC_PEND]) &
                ~(arb_q == ARB_WAIT && fetch_done && !st_sw_q &&
                  ack_idx_q == i[5:0]));
         if (src_wr)
            source_priority_level_q[src_sel] <= HWDATA[2:0];
      end
   end

   // ==========================================================
   // Trap request and grant sequencer
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         trap_pend_q <= 1'b0;
         trap_vec_q  <= 6'h00;
         arb_q       <= ARB_IDLE;
         start_q     <= 1'b0;
         st_vec_q    <= 6'h00;
         st_sw_q     <= 1'b0;
         ack_idx_q   <= 6'h00;
      end
      else
      begin
         start_q <= 1'b0;
         // A trap written while one waits is dropped
         if (wr_stb && reg_addr == `RVAM_OFS_TRAP && !trap_pend_q)
         begin
            trap_pend_q <= 1'b1;
            if (HWDATA[`RVAM_TRAP_BRK])
               trap_vec_q <= `RVAM_VEC_BREAK;
            else
               trap_vec_q <= HWDATA[5:0];
         end
         case (arb_q)
            ARB_IDLE:
               if (!fetch_busy && !start_q)
               begin
                  if (trap_pend_q)
                  begin
                     // Traps bypass the global enable
                     start_q     <= 1'b1;
                     st_vec_q    <= trap_vec_q;
                     st_sw_q     <= 1'b1;
                     trap_pend_q <= 1'b0;
                     arb_q       <= ARB_WAIT;
                  end
                  else if (CORE_GLOBAL_ENABLE && hit)
                  begin
                     start_q   <= 1'b1;
                     st_vec_q  <= src_to_vec(best_idx);
                     st_sw_q   <= 1'b0;
                     ack_idx_q <= best_idx;
                     arb_q     <= ARB_WAIT;
                  end
               end
            ARB_WAIT:
               if (fetch_done)
                  arb_q <= ARB_IDLE;
            default:
               arb_q <= ARB_IDLE;
         endcase
      end
   end
endmodule // rvam_top

// ==== rtl/rvam_defines.vh ====
// Constants for the relocatable vector address map
`ifndef RVAM_DEFINES_VH
`define RVAM_DEFINES_VH
// ==========================================================
// Register byte offsets
`define RVAM_OFS_VBASE   12'h000
`define RVAM_OFS_CTRL    12'h004
`define RVAM_OFS_TRAP    12'h008
`define RVAM_OFS_STAT    12'h00c
`define RVAM_OFS_HNDL    12'h010
`define RVAM_SRC_PAGE    4'h1
// ==========================================================
// Field positions
`define RVAM_CTRL_SEL03  5
`define RVAM_CTRL_SEL14  6
`define RVAM_TRAP_BRK    8
`define RVAM_TRAP_PEND   8
`define RVAM_SRC_PEND    3
// ==========================================================
// Reset values
`define RVAM_VBASE_RST   24'h000000
`define RVAM_I2C_RST     5'h00
`define RVAM_LVL_RST     3'h0
// ==========================================================
// Table geometry and vector numbers
`define RVAM_NUM_SRC     36
`define RVAM_OFS_MASK    8'hff
`define RVAM_VEC_BREAK   6'h00
`define RVAM_VEC_HW_LO   6'h08
`define RVAM_VEC_TMRA    6'h0c
`define RVAM_VEC_SER01   6'h11
`define RVAM_VEC_TMRB    6'h15
`define RVAM_VEC_EXT     6'h1a
`define RVAM_VEC_TMRB5   6'h20
`define RVAM_VEC_SER24   6'h21
`define RVAM_VEC_EVT2    6'h27
`define RVAM_VEC_EVT03   6'h28
`define RVAM_VEC_EVT14   6'h29
`define RVAM_VEC_ADC0    6'h2a
`define RVAM_VEC_KEY     6'h2b
// ==========================================================
// Timing: bytes per slot, one byte read per cycle
`define RVAM_LAST_STEP   3'h4
`endif

// ==== rtl/rvam_ahb.v ====
// AHB-Lite slave front end for the vector map registers
`timescale 1ns/10ps
module rvam_ahb (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire        hready,
   input  wire [31:0] rdata,
   output reg  [31:0] hrdata_q,
   output reg         hreadyout_q,
   output reg         hresp_q,
   output reg  [11:0] addr_q,
   output reg         wr_q
);
   reg rd_q;
   wire accept = hsel & htrans[1] & hready;
   // ==========================================================
   // Reads take one wait state so a write just before is seen
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hrdata_q    <= 32'h00000000;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
         addr_q      <= 12'h000;
         wr_q        <= 1'b0;
         rd_q        <= 1'b0;
      end
      else if (accept)
      begin
         addr_q      <= haddr;
         wr_q        <= hwrite;
         rd_q        <= ~hwrite;
         hreadyout_q <= hwrite;
      end
      else
      begin
         wr_q <= 1'b0;
         if (rd_q)
         begin
            hrdata_q    <= rdata;
            hreadyout_q <= 1'b1;
            rd_q        <= 1'b0;
         end
      end
   end
endmodule // rvam_ahb

// ==== rtl/rvam_fetch.v ====
// Handler address fetch: four byte reads from the vector slot
`timescale 1ns/10ps
`include "rvam_defines.vh"
module rvam_fetch (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        start,
   input  wire [5:0]  vec,
   input  wire        sw,
   input  wire [23:0] base,
   input  wire [7:0]  mem_rdata,
   output reg  [23:0] mem_addr_q,
   output reg         mem_rd_q,
   output reg  [31:0] handler_q,
   output reg  [5:0]  vec_q,
   output reg         sw_q,
   output reg         done_q,
   output reg         busy_q
);
   reg [2:0]  step_q;
   reg [23:0] bytes_q;
   wire [7:0] slot_ofs = {vec, 2'b00} & `RVAM_OFS_MASK;
   // ==========================================================
   // Byte k is read in step k and captured in step k+1
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_addr_q <= 24'h000000;
         mem_rd_q   <= 1'b0;
         handler_q  <= 32'h00000000;
         vec_q      <= 6'h00;
         sw_q       <= 1'b0;
         done_q     <= 1'b0;
         busy_q     <= 1'b0;
         step_q     <= 3'h0;
         bytes_q    <= 24'h000000;
      end
      else
      begin
         done_q <= 1'b0;
         if (!busy_q && start)
         begin
            mem_addr_q <= base + {16'h0000, slot_ofs};
            mem_rd_q   <= 1'b1;
            vec_q      <= vec;
            sw_q       <= sw;
            busy_q     <= 1'b1;
            step_q     <= 3'h0;
         end
         else if (busy_q)
         begin
            if (step_q == `RVAM_LAST_STEP)
            begin
               handler_q <= {mem_rdata, bytes_q};
               done_q    <= 1'b1;
               busy_q    <= 1'b0;
            end
            else
            begin
               if (step_q != 3'h0)
                  bytes_q <= {mem_rdata, bytes_q[23:8]};
               if (step_q < 3'h3)
                  mem_addr_q <= mem_addr_q + 24'h000001;
               else
                  mem_rd_q <= 1'b0;
               step_q <= step_q + 3'h1;
            end
         end
      end
   end
endmodule // rvam_fetch

// ==== tb/rvam_props.sv ====
// Concurrent checks on the vector map top-level ports
`timescale 1ns/10ps
module rvam_props (
   input logic        CLK,
   input logic        RESET_N,
   input logic        HSEL,
   input logic [31:0] HADDR,
   input logic [1:0]  HTRANS,
   input logic        HWRITE,
   input logic [31:0] HWDATA,
   input logic        HREADY,
   input logic        HREADYOUT,
   input logic        HRESP,
   input logic [23:0] MEM_ADDR,
   input logic        MEM_RD,
   input logic [7:0]  MEM_RDATA,
   input logic [31:0] HANDLER_ADDR,
   input logic        HANDLER_VALID,
   input logic [5:0]  HANDLER_VEC,
   input logic        HANDLER_SW
);
   logic        wr_base_q;
   logic        wr_trap_q;
   logic [23:0] base_q;
   wire         take = HSEL && HTRANS[1] && HREADY;
   // ==========================================================
   // Shadow of the base register, so slot addresses can be judged
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         wr_base_q <= 1'b0;
         wr_trap_q <= 1'b0;
         base_q    <= 24'h000000;
      end
      else
      begin
         wr_base_q <= take && HWRITE && HADDR[11:0] == 12'h000;
         wr_trap_q <= take && HWRITE && HADDR[11:0] == 12'h008;
         if (wr_base_q)
            base_q <= HWDATA[23:0];
      end
   end
   // ==========================================================
   // Properties
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   sequence rd_burst;
      MEM_RD [*4] ##1 !MEM_RD;
   endsequence
   sequence fetch_end;
      ##5 HANDLER_VALID ##1 !HANDLER_VALID;
   endsequence
   slot_addr_a: assert property ($rose(MEM_RD) |->
      MEM_ADDR == base_q + {16'h0000, HANDLER_VEC, 2'b00}) else $error("slot address wrong");
   slot_bytes_a: assert property ($rose(MEM_RD) |-> rd_burst)
      else $error("slot read not four bytes");
   byte_step_a: assert property (MEM_RD && $past(MEM_RD) |->
      MEM_ADDR == $past(MEM_ADDR) + 24'h000001) else $error("byte address not ascending");
   valid_time_a: assert property ($rose(MEM_RD) |-> fetch_end)
      else $error("handler valid late or long");
   handler_asm_a: assert property (HANDLER_VALID |-> HANDLER_ADDR ==
      {$past(MEM_RDATA, 1), $past(MEM_RDATA, 2), $past(MEM_RDATA, 3), $past(MEM_RDATA, 4)})
      else $error("handler bytes misassembled");
   hw_range_a: assert property (HANDLER_VALID && !HANDLER_SW |->
      HANDLER_VEC >= 6'h08 && HANDLER_VEC <= 6'h2b) else $error("hardware vector out of range");
   trap_fetch_a: assert property (wr_trap_q |-> ##[2:20] ($rose(MEM_RD) && HANDLER_SW))
      else $error("trap not fetched");
   read_wait_a: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read wait state wrong");
   resp_ok_a: assert property (HRESP == 1'b0)
      else $error("response not okay");
endmodule // rvam_props

bind rvam_top rvam_props chk (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
   .MEM_RDATA(MEM_RDATA), .HANDLER_ADDR(HANDLER_ADDR), .HANDLER_VALID(HANDLER_VALID),
   .HANDLER_VEC(HANDLER_VEC), .HANDLER_SW(HANDLER_SW));

// ==== tb/rvam_mem.sv ====
// Behavioural vector table memory answering the handler fetch reads
`timescale 1ns/10ps
module rvam_mem (
   input  logic        CLK,
   input  logic        RESET_N,
   input  logic [23:0] MEM_ADDR,
   input  logic        MEM_RD,
   output logic [7:0]  MEM_RDATA
);
   // Content hashes every address bit so a wrong slot or wrap shows up
   function automatic logic [7:0] byte_at(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
   endfunction
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         MEM_RDATA <= 8'h00;
      else if (MEM_RD)
         MEM_RDATA <= byte_at(MEM_ADDR);
      else
         MEM_RDATA <= ~MEM_RDATA; // Idle bus never repeats a stale byte
   end
endmodule // rvam_mem

// ==== tb/tb.sv ====
// Self-checking bench for the relocatable vector address map
`timescale 1ns/10ps
module tb;
   logic        CLK;
   logic        RESET_N;
   logic        HSEL;
   logic [31:0] HADDR;
   logic [1:0]  HTRANS;
   logic        HWRITE;
   logic [31:0] HWDATA;
   logic        CORE_GLOBAL_ENABLE;
   logic [2:0]  PROCESSOR_PRIORITY_LEVEL;
   logic [47:0] req;
   logic [31:0] rd;
   logic [23:0] base;
   logic [23:0] rows[$];
   wire  [31:0] HRDATA;
   wire         HREADYOUT;
   wire         HRESP;
   wire  [23:0] MEM_ADDR;
   wire         MEM_RD;
   wire  [7:0]  MEM_RDATA;
   wire  [31:0] HANDLER_ADDR;
   wire         HANDLER_VALID;
   wire  [5:0]  HANDLER_VEC;
   wire         HANDLER_SW;
   int          error_cnt;
   int          compares;
   int          i;
   rvam_top uut (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DMA_DONE(req[3:0]), .TMRA_REQ(req[8:4]),
      .TMRB_REQ(req[14:9]), .SER_TX_REQ(req[19:15]), .SER_RX_REQ(req[24:20]),
      .SER_NACK(req[29:25]), .SER_ACK(req[34:30]), .SER_BUS_EVT(req[39:35]),
      .EXT_REQUEST_PIN(req[45:40]), .ADC_CHANNEL_ZERO_DONE(req[46]), .KEY_REQ(req[47]),
      .CORE_GLOBAL_ENABLE(CORE_GLOBAL_ENABLE),
      .PROCESSOR_PRIORITY_LEVEL(PROCESSOR_PRIORITY_LEVEL), .MEM_ADDR(MEM_ADDR),
      .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA), .HANDLER_ADDR(HANDLER_ADDR),
      .HANDLER_VALID(HANDLER_VALID), .HANDLER_VEC(HANDLER_VEC), .HANDLER_SW(HANDLER_SW));
   rvam_mem mem (.CLK(CLK), .RESET_N(RESET_N), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
      .MEM_RDATA(MEM_RDATA));
   initial
   begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   // ==========================================================
   // Tasks
   function automatic logic [7:0] f(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {20'h00000, a};
      HWRITE <= w;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask
   task automatic add(input logic [7:0] c, input logic [7:0] b, input logic [7:0] v);
      rows.push_back({c, b, v});
   endtask
   task automatic src(input logic [7:0] b);
      req[b] <= 1'b1;
      repeat (2) @(posedge CLK);
      req[b] <= 1'b0;
   endtask
   task automatic quiet;
      repeat (20)
      begin
         @(posedge CLK);
         check(MEM_RD, 32'h0);
      end
   endtask
   task automatic fetch_chk(input logic [5:0] v, input logic sw);
      logic [23:0] a;
      a = base + {16'h0000, v, 2'b00};
      repeat (40)
      begin
         @(posedge CLK);
         if (HANDLER_VALID === 1'b1)
            break;
      end
      check(HANDLER_VALID, 32'h1);
      check(HANDLER_VEC, v);
      check(HANDLER_SW, sw);
      check(HANDLER_ADDR, {f(a + 24'h3), f(a + 24'h2), f(a + 24'h1), f(a)});
      @(posedge CLK);
   endtask
   task automatic summarize;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #1600000;
      error_cnt++;
      summarize;
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      {RESET_N, HSEL, HADDR, HTRANS, HWRITE, HWDATA, CORE_GLOBAL_ENABLE} = '0;
      PROCESSOR_PRIORITY_LEVEL = 3'h0;
      req = '0;
      error_cnt = 0;
      compares = 0;
      for (i = 0; i < 4; i++) add(8'h00, i, 8 + i);
      for (i = 0; i < 5; i++) add(8'h00, 4 + i, 12 + i);
      for (i = 0; i < 5; i++) add(8'h00, 9 + i, 21 + i);
      add(8'h00, 14, 32);
      add(8'h00, 15, 17);
      add(8'h00, 20, 18);
      add(8'h00, 16, 19);
      add(8'h00, 21, 20);
      for (i = 2; i < 5; i++) add(8'h00, 15 + i, 29 + 2 * i);
      for (i = 2; i < 5; i++) add(8'h00, 20 + i, 30 + 2 * i);
      add(8'h1f, 25, 17);
      add(8'h1f, 30, 18);
      add(8'h1f, 29, 37);
      add(8'h1f, 34, 38);
      add(8'h04, 37, 39);
      add(8'h21, 35, 40);
      add(8'h08, 38, 40);
      add(8'h42, 36, 41);
      add(8'h10, 39, 41);
      for (i = 0; i < 6; i++) add(8'h00, 40 + i, 31 - i);
      add(8'h00, 46, 42);
      add(8'h00, 47, 43);
      for (i = 0; i < 64; i++) add(8'h00, 8'hff, i);
      repeat (12) @(posedge CLK);
      RESET_N <= 1'b1;
      @(posedge CLK);
      base = 24'h012345;
      bus(1'b1, 12'h000, {8'h00, base});
      for (i = 0; i < 36; i++) bus(1'b1, 12'h100 + 4 * i, 32'h1);
      foreach (rows[k])
      begin
         bus(1'b1, 12'h004, {24'h000000, rows[k][23:16]});
         CORE_GLOBAL_ENABLE <= rows[k][15:8] != 8'hff;
         if (rows[k][15:8] == 8'hff)
            bus(1'b1, 12'h008, {26'h0, rows[k][5:0]});
         else
            src(rows[k][15:8]);
         fetch_chk(rows[k][5:0], rows[k][15:8] == 8'hff);
      end
      bus(1'b1, 12'h008, 32'h100);
      fetch_chk(6'h00, 1'b1);
      CORE_GLOBAL_ENABLE <= 1'b0;
      src(0);
      quiet;
      bus(1'b0, 12'h100, 32'h0);
      check(rd[3:0], 32'h9);
      PROCESSOR_PRIORITY_LEVEL <= 3'h1;
      CORE_GLOBAL_ENABLE <= 1'b1;
      quiet;
      PROCESSOR_PRIORITY_LEVEL <= 3'h0;
      fetch_chk(6'h08, 1'b0);
      bus(1'b1, 12'h100, 32'h9);
      bus(1'b0, 12'h100, 32'h0);
      check(rd[3:0], 32'h1);
      base = 24'hfffff1;
      bus(1'b1, 12'h000, {8'h00, base});
      bus(1'b1, 12'h008, 32'h3f);
      fetch_chk(6'h3f, 1'b1);
      // Last handler, status and trap registers after a trap fetch
      bus(1'b0, 12'h010, 32'h0);
      check(rd, {f(base + 24'hff), f(base + 24'hfe),
                 f(base + 24'hfd), f(base + 24'hfc)});
      bus(1'b0, 12'h00c, 32'h0);
      check(rd, 32'h23f);
      bus(1'b0, 12'h008, 32'h0);
      check(rd, 32'h3f);
      bus(1'b0, 12'h0fc, 32'h0);
      check(rd, 32'h0);
      RESET_N <= 1'b0;
      repeat (2) @(posedge CLK);
      check(HANDLER_ADDR, 32'h0);
      check(HRDATA, 32'h0);
      check({HRESP, HANDLER_VEC, HANDLER_SW, HANDLER_VALID, MEM_RD, HREADYOUT}, 32'h1);
      RESET_N <= 1'b1;
      @(posedge CLK);
      bus(1'b0, 12'h000, 32'h0);
      check(rd, 32'h0);
      bus(1'b0, 12'h100, 32'h0);
      check(rd, 32'h0);
      summarize;
   end
endmodule // tb
